// ===== rtl/ucw_pkg.sv
// package for the serial port control slice: register map, field positions,
// reset values, prescale counts and interrupt status layout.
// assumes an 8-bit software port with a 3-bit word address.
package ucw_pkg;
    // register word addresses
    localparam logic [2:0] UCW_ADDR_CTRL = 3'h0;
    localparam logic [2:0] UCW_ADDR_DIV = 3'h1;
    localparam logic [2:0] UCW_ADDR_STATUS = 3'h2;
    localparam logic [2:0] UCW_ADDR_MASK = 3'h3;
    localparam logic [2:0] UCW_ADDR_RXDATA = 3'h4;
    localparam logic [2:0] UCW_ADDR_RXINFO = 3'h5;
    localparam logic [2:0] UCW_ADDR_CLKCTRL = 3'h6;

    // control register fields
    localparam int UCW_CTRL_NINE_BIT = 6;
    localparam int UCW_CTRL_HIGH_SPEED = 5;
    localparam int UCW_CTRL_ADDR_DETECT = 4;
    localparam int UCW_CTRL_WAKE_EN = 3;
    localparam int UCW_CTRL_RX_IRQ_EN = 2;
    localparam logic [7:0] UCW_CTRL_RESET = 8'h00;
    localparam logic [7:0] UCW_CTRL_WMASK = 8'h7C;

    // divider register
    localparam logic [7:0] UCW_DIV_RESET = 8'h00;

    // clock control register: bit 0 switches the serial clock on
    localparam int UCW_CLK_ON = 0;
    localparam logic UCW_CLK_ON_RESET = 1'b0;

    // interrupt status and mask layout
    localparam int UCW_IRQ_W = 3;
    localparam int UCW_IRQ_RX = 0;
    localparam int UCW_IRQ_ADDR = 1;
    localparam int UCW_IRQ_WAKE = 2;
    localparam logic [UCW_IRQ_W-1:0] UCW_STATUS_RESET = 3'h0;
    localparam logic [UCW_IRQ_W-1:0] UCW_MASK_RESET = 3'h0;

    // received word info bits
    localparam int UCW_INFO_IS_ADDR = 0;
    localparam int UCW_INFO_NINTH = 1;

    // baud prescale: last count of the per-bit sample counter
    localparam logic [5:0] UCW_PRE_LAST_HIGH = 6'h0F;
    localparam logic [5:0] UCW_PRE_LAST_LOW = 6'h3F;
    localparam logic [5:0] UCW_PRE_RESET = 6'h00;

    // wake-up pin synchroniser reset level: line idles high
    localparam logic UCW_LINE_IDLE = 1'b1;
endpackage

// ===== rtl/ucw_baud_gen.sv
// baud rate generator: a divider reload counter followed by a sample
// prescaler whose length depends on the speed mode.
// assumes run comes from a register on the same clock.
`timescale 1ns/1ps
module ucw_baud_gen
    import ucw_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic run,
    input wire logic high_speed,
    input wire logic [7:0] divider,
    output logic sample_tick,
    output logic bit_tick
);
    logic [7:0] div_cnt_q;
    logic [5:0] pre_cnt_q;
    logic [5:0] pre_last;
    logic step;

    // speed mode picks the prescale length [RULE_02]
    assign pre_last = high_speed ? UCW_PRE_LAST_HIGH : UCW_PRE_LAST_LOW;
    assign step = run && (div_cnt_q == 8'h00);

    // divider counts down from the software value [RULE_01]
    always_ff @(posedge clk) begin
        if (reset || !run) begin
            div_cnt_q <= UCW_DIV_RESET;
        end else if (div_cnt_q == 8'h00) begin
            div_cnt_q <= divider;
        end else begin
            div_cnt_q <= div_cnt_q - 8'h01;
        end
    end

    // prescaler turns divider steps into one tick per bit [RULE_01]
    always_ff @(posedge clk) begin
        if (reset || !run) begin
            pre_cnt_q <= UCW_PRE_RESET;
        end else if (step) begin
            if (pre_cnt_q >= pre_last) begin
                pre_cnt_q <= UCW_PRE_RESET;
            end else begin
                pre_cnt_q <= pre_cnt_q + 6'h01;
            end
        end
    end

    // ticks are single-cycle enables, never clocks
    always_ff @(posedge clk) begin
        if (reset) begin
            sample_tick <= 1'b0;
            bit_tick <= 1'b0;
        end else begin
            sample_tick <= step;
            bit_tick <= step && (pre_cnt_q >= pre_last);
        end
    end
endmodule

// ===== rtl/ucw_ctrl.sv
// serial port control slice: baud mode and divider, multiprocessor address
// detection on received words, pin wake-up while the serial clock is off,
// and an interrupt status/mask pair behind a plain register port.
// assumes the receiver core delivers words and flags on the same clock,
// and that the shared rx/tx pin arrives unsynchronised.
// Functional notes
// RULE_01: the bit rate comes from the speed select bit and the software divider value.
// RULE_02: speed select 1 gives the high speed mode, 0 the low speed mode.
// RULE_03: control bit 4 turns address detection on when 1 and off when 0.
// RULE_04: with detection on a word is an address when bit 8 (eight-bit) or bit 9 (nine-bit) is 1.
// RULE_05: with detection and the receive interrupt on, each address word raises a request.
// RULE_06: with detection on a word whose marker is 0 raises nothing and is dropped.
// RULE_07: control bit 3 enables a wake-up request on a falling edge of the serial pin.
// RULE_08: pin wake-up acts only while the serial clock is off.
// RULE_09: a wake-up request raises an interrupt and software must switch the clock back on.
// RULE_10: with the clock still off the port stays idle whatever the pin does.
// RULE_11: with the receive interrupt enabled an overrun or a new data flag sets the request.
// RULE_12: with detection off every word is plain data whatever its top bit.
//
// The strobed register port and the register offsets were left to the implementer.

`timescale 1ns/1ps
module ucw_ctrl
    import ucw_pkg::*;
(
    input wire logic clk,
    input wire logic reset,

    // software register port
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,

    // serial pin and receiver core
    input wire logic rx_pin,
    input wire logic rx_word_valid,
    input wire logic [8:0] rx_word,
    input wire logic overrun_flag,
    input wire logic receive_available_flag,

    // baud and word format settings
    output logic serial_clock_on,
    output logic baud_high_speed_select,
    output logic [7:0] baud_divider_value,
    output logic nine_bit_word_select,
    output logic sample_tick,
    output logic bit_tick,

    // received word, wake-up and interrupt
    output logic word_accept,
    output logic [7:0] word_data,
    output logic word_is_address,
    output logic wake_request,
    output logic irq
);
    // software registers
    logic [7:0] ctrl_q;
    logic [7:0] div_q;
    logic clk_on_q;

    // interrupt status, mask and their events
    logic [UCW_IRQ_W-1:0] status_q;
    logic [UCW_IRQ_W-1:0] status_d;
    logic [UCW_IRQ_W-1:0] mask_q;
    logic [UCW_IRQ_W-1:0] set_ev;
    logic [UCW_IRQ_W-1:0] clr_ev;

    // read path
    logic [7:0] rdata_d;

    // kept word and its classification
    logic [7:0] word_data_q;
    logic word_addr_q;
    logic word_ninth_q;
    logic word_accept_q;

    // wake request level
    logic wake_q;

    // pin synchroniser and edge detector
    logic pin_meta_q;
    logic pin_sync_q;
    logic pin_prev_q;
    logic pin_fall;

    // receiver flag edges
    logic ovr_prev_q;
    logic avail_prev_q;
    logic flag_rise;

    // decoded control bits and word qualifiers
    logic addr_detect;
    logic wake_enable;
    logic rx_irq_enable;
    logic marker;
    logic word_live;
    logic keep_word;

    // write strobes, one per writable register
    logic wr_ctrl;
    logic wr_div;
    logic wr_status;
    logic wr_mask;
    logic wr_clk;

    // address decoding for writes
    always_comb begin
        wr_ctrl = 1'b0;
        wr_div = 1'b0;
        wr_status = 1'b0;
        wr_mask = 1'b0;
        wr_clk = 1'b0;
        if (reg_wr && reg_addr == UCW_ADDR_CTRL) begin
            wr_ctrl = 1'b1;
        end else if (reg_wr && reg_addr == UCW_ADDR_DIV) begin
            wr_div = 1'b1;
        end else if (reg_wr && reg_addr == UCW_ADDR_STATUS) begin
            wr_status = 1'b1;
        end else if (reg_wr && reg_addr == UCW_ADDR_MASK) begin
            wr_mask = 1'b1;
        end else if (reg_wr && reg_addr == UCW_ADDR_CLKCTRL) begin
            wr_clk = 1'b1;
        end
    end

    // control register: only the documented bits are writable
    always_ff @(posedge clk) begin
        if (reset) begin
            ctrl_q <= UCW_CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_q <= reg_wdata & UCW_CTRL_WMASK;
        end
    end

    // divider value, applied at the next reload of the counter
    always_ff @(posedge clk) begin
        if (reset) begin
            div_q <= UCW_DIV_RESET;
        end else if (wr_div) begin
            div_q <= reg_wdata;
        end
    end

    // serial clock switch: only software turns it back on [RULE_09]
    always_ff @(posedge clk) begin
        if (reset) begin
            clk_on_q <= UCW_CLK_ON_RESET;
        end else if (wr_clk) begin
            clk_on_q <= reg_wdata[UCW_CLK_ON];
        end
    end

    // interrupt mask
    always_ff @(posedge clk) begin
        if (reset) begin
            mask_q <= UCW_MASK_RESET;
        end else if (wr_mask) begin
            mask_q <= reg_wdata[UCW_IRQ_W-1:0];
        end
    end

    // enables decoded from the control register
    assign addr_detect = ctrl_q[UCW_CTRL_ADDR_DETECT]; // [RULE_03]
    assign wake_enable = ctrl_q[UCW_CTRL_WAKE_EN];
    assign rx_irq_enable = ctrl_q[UCW_CTRL_RX_IRQ_EN];

    // format, speed and clock settings seen by the rest of the port
    assign nine_bit_word_select = ctrl_q[UCW_CTRL_NINE_BIT];
    assign baud_high_speed_select = ctrl_q[UCW_CTRL_HIGH_SPEED];
    assign baud_divider_value = div_q;
    assign serial_clock_on = clk_on_q;

    // baud generator halts with the serial clock; ticks stop one cycle after switch-off
    ucw_baud_gen u_baud (
        .clk(clk),
        .reset(reset),
        .run(clk_on_q), // [RULE_10]
        .high_speed(baud_high_speed_select), // [RULE_02]
        .divider(div_q), // [RULE_01]
        .sample_tick(sample_tick),
        .bit_tick(bit_tick)
    );

    // two-flop synchroniser on the pin; the first stage feeds only the second
    always_ff @(posedge clk) begin
        if (reset) begin
            pin_meta_q <= UCW_LINE_IDLE;
            pin_sync_q <= UCW_LINE_IDLE;
        end else begin
            pin_meta_q <= rx_pin;
            pin_sync_q <= pin_meta_q;
        end
    end

    // last synchronised level; reset to idle so no false edge follows reset
    always_ff @(posedge clk) begin
        if (reset) begin
            pin_prev_q <= UCW_LINE_IDLE;
        end else begin
            pin_prev_q <= pin_sync_q;
        end
    end

    // falling edge of the synchronised line [RULE_07]
    assign pin_fall = pin_prev_q && !pin_sync_q;

    // marker is the top bit of the word: bit 8 of nine, bit 7 of eight [RULE_04]
    assign marker = nine_bit_word_select ? rx_word[8] : rx_word[7];

    // words arriving while the clock is off are ignored [RULE_10]
    assign word_live = rx_word_valid && clk_on_q;

    // detection off keeps every word; on keeps only addresses [RULE_06] [RULE_12]
    assign keep_word = word_live && (!addr_detect || marker);

    // kept word data, held until the next kept word
    always_ff @(posedge clk) begin
        if (reset) begin
            word_data_q <= 8'h00;
        end else if (keep_word) begin
            word_data_q <= rx_word[7:0];
        end
    end

    // classification and ninth bit of the kept word, held alongside its data
    always_ff @(posedge clk) begin
        if (reset) begin
            word_addr_q <= 1'b0;
            word_ninth_q <= 1'b0;
        end else if (keep_word) begin
            word_addr_q <= addr_detect && marker; // [RULE_04] [RULE_12]
            word_ninth_q <= rx_word[8];
        end
    end

    // one-cycle acceptance pulse toward the receive buffer
    always_ff @(posedge clk) begin
        if (reset) begin
            word_accept_q <= 1'b0;
        end else begin
            word_accept_q <= keep_word; // [RULE_06]
        end
    end

    // word outputs come straight from their registers
    assign word_accept = word_accept_q;
    assign word_data = word_data_q;
    assign word_is_address = word_addr_q;

    // overrun edge; a flag held high counts once
    always_ff @(posedge clk) begin
        if (reset) begin
            ovr_prev_q <= 1'b0;
        end else begin
            ovr_prev_q <= overrun_flag;
        end
    end

    // data-available edge, kept apart from the overrun edge
    always_ff @(posedge clk) begin
        if (reset) begin
            avail_prev_q <= 1'b0;
        end else begin
            avail_prev_q <= receive_available_flag;
        end
    end

    // either rising flag is one receive event [RULE_11]
    assign flag_rise = (overrun_flag && !ovr_prev_q) ||
                       (receive_available_flag && !avail_prev_q);

    // status events; rx and address events need the receive enable
    always_comb begin
        set_ev = '0;
        set_ev[UCW_IRQ_RX] = rx_irq_enable && flag_rise; // [RULE_11]
        set_ev[UCW_IRQ_ADDR] = rx_irq_enable && word_live && addr_detect && marker; // [RULE_05]
        set_ev[UCW_IRQ_WAKE] = wake_enable && !clk_on_q && pin_fall; // [RULE_07] [RULE_08]
    end

    // software clear: only the bits written as one
    assign clr_ev = wr_status ? reg_wdata[UCW_IRQ_W-1:0] : '0;

    // write-one-to-clear, a coincident set wins so no event is lost
    assign status_d = (status_q & ~clr_ev) | set_ev;

    // sticky status register
    always_ff @(posedge clk) begin
        if (reset) begin
            status_q <= UCW_STATUS_RESET;
        end else begin
            status_q <= status_d;
        end
    end

    // wake request level: holds until software switches the clock on [RULE_09]
    always_ff @(posedge clk) begin
        if (reset) begin
            wake_q <= 1'b0;
        end else if (clk_on_q) begin
            wake_q <= 1'b0; // [RULE_08]
        end else if (set_ev[UCW_IRQ_WAKE]) begin
            wake_q <= 1'b1; // [RULE_07]
        end
    end

    // wake request straight from its register
    assign wake_request = wake_q;

    // level interrupt while any unmasked status bit stands [RULE_09] [RULE_05]
    assign irq = |(status_q & mask_q);

    // read mux; unmapped addresses read zero
    always_comb begin
        rdata_d = 8'h00;
        if (reg_addr == UCW_ADDR_CTRL) begin
            rdata_d = ctrl_q;
        end else if (reg_addr == UCW_ADDR_DIV) begin
            rdata_d = div_q;
        end else if (reg_addr == UCW_ADDR_STATUS) begin
            rdata_d[UCW_IRQ_W-1:0] = status_q;
        end else if (reg_addr == UCW_ADDR_MASK) begin
            rdata_d[UCW_IRQ_W-1:0] = mask_q;
        end else if (reg_addr == UCW_ADDR_RXDATA) begin
            rdata_d = word_data_q;
        end else if (reg_addr == UCW_ADDR_RXINFO) begin
            rdata_d[UCW_INFO_IS_ADDR] = word_addr_q;
            rdata_d[UCW_INFO_NINTH] = word_ninth_q;
        end else if (reg_addr == UCW_ADDR_CLKCTRL) begin
            rdata_d[UCW_CLK_ON] = clk_on_q;
        end
    end

    // read data registered for the cycle after the strobe, zero otherwise
    always_ff @(posedge clk) begin
        if (reset) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rdata_d;
        end else begin
            reg_rdata <= 8'h00;
        end
    end
endmodule

// ===== test/ucw_ctrl_chk.sv
// checker for the serial control slice: baud tick gating, word keeping
// and pin wake-up, judged only at the ports of ucw_ctrl.
// assumes one clock domain with a synchronous active high reset.
`timescale 1ns/1ps
module ucw_ctrl_chk (
    input wire logic clk,
    input wire logic reset,
    input wire logic serial_clock_on,
    input wire logic nine_bit_word_select,
    input wire logic rx_word_valid,
    input wire logic [8:0] rx_word,
    input wire logic word_accept,
    input wire logic [7:0] word_data,
    input wire logic word_is_address,
    input wire logic wake_request,
    input wire logic sample_tick,
    input wire logic bit_tick
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // the ticks are registered, so one cycle of slack after switch-off
    ticks_idle_a: assert property (
        !serial_clock_on && !$past(serial_clock_on) |-> !sample_tick && !bit_tick)
        else $error("baud tick with serial clock off");
    // shortest bit is sixteen steps, so eight quiet cycles always hold
    bit_gap_a: assert property (
        bit_tick |=> (!bit_tick) [*8])
        else $error("bit ticks too close");
    wake_off_a: assert property (
        $rose(wake_request) |-> !$past(serial_clock_on))
        else $error("wake raised with clock on");
    wake_clear_a: assert property (
        $rose(serial_clock_on) |-> ##[1:2] !wake_request)
        else $error("wake not cleared");
    word_gate_a: assert property (
        rx_word_valid && !serial_clock_on |=> !word_accept)
        else $error("word kept with clock off");
    word_cause_a: assert property (
        word_accept |-> $past(rx_word_valid && serial_clock_on))
        else $error("accept without a word");
    word_data_a: assert property (
        word_accept |-> word_data == $past(rx_word[7:0]))
        else $error("kept data differs");
    addr_mark_a: assert property (
        word_accept && word_is_address |-> $past(nine_bit_word_select ? rx_word[8] : rx_word[7]))
        else $error("address without marker");
endmodule

bind ucw_ctrl ucw_ctrl_chk chk (.clk(clk), .reset(reset), .serial_clock_on(serial_clock_on),
    .nine_bit_word_select(nine_bit_word_select), .rx_word_valid(rx_word_valid),
    .rx_word(rx_word), .word_accept(word_accept), .word_data(word_data),
    .word_is_address(word_is_address), .wake_request(wake_request),
    .sample_tick(sample_tick), .bit_tick(bit_tick));

// ===== test/ucw_line_tx.sv
// remote serial transmitter model driving the shared line.
// assumes a pull-up on the line, so idle reads as 1.
`timescale 1ns/1ps
module ucw_line_tx #(
    parameter int BIT_NS = 400
) (
    output logic line
);
    initial line = 1'b1;

    // one frame: start low, eight bits lsb first, stop high
    task automatic send(input logic [7:0] b);
        line = 1'b0;
        #(BIT_NS);
        for (int i = 0; i < 8; i++) begin
            line = b[i];
            #(BIT_NS);
        end
        line = 1'b1;
        #(BIT_NS);
    endtask
endmodule

// ===== test/uart_ctrl_baud_addr_wake_tb.sv
// testbench for ucw_ctrl: register port, baud ticks, address detection,
// flag events and pin wake-up; the line comes from the transmitter model.
`timescale 1ns/1ps
module uart_ctrl_baud_addr_wake_tb;
    import ucw_pkg::*;
    logic clk;
    logic reset = 1'b1;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic rx_pin;
    logic rx_word_valid = 1'b0;
    logic [8:0] rx_word = 9'h000;
    logic overrun_flag = 1'b0;
    logic receive_available_flag = 1'b0;
    logic serial_clock_on, baud_high_speed_select, nine_bit_word_select;
    logic sample_tick, bit_tick, word_accept, word_is_address, wake_request, irq;
    logic [7:0] baud_divider_value, word_data;
    int n_fail = 0;
    int n_checks = 0;

    ucw_line_tx line (.line(rx_pin));
    ucw_ctrl dut (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_pin(rx_pin),
        .rx_word_valid(rx_word_valid), .rx_word(rx_word), .overrun_flag(overrun_flag),
        .receive_available_flag(receive_available_flag), .serial_clock_on(serial_clock_on),
        .baud_high_speed_select(baud_high_speed_select),
        .baud_divider_value(baud_divider_value), .nine_bit_word_select(nine_bit_word_select),
        .sample_tick(sample_tick), .bit_tick(bit_tick), .word_accept(word_accept),
        .word_data(word_data), .word_is_address(word_is_address),
        .wake_request(wake_request), .irq(irq));

    // 20 MHz clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic final_report;
        if (n_fail == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(negedge clk);
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rdchk(input string nm, input logic [2:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        chk(nm, reg_rdata, e);
    endtask

    task automatic send_word(input logic [8:0] w, input logic keep, input logic isa);
        @(posedge clk);
        rx_word_valid <= 1'b1;
        rx_word <= w;
        @(posedge clk);
        rx_word_valid <= 1'b0;
        @(negedge clk);
        chk("word_accept", word_accept, keep);
        if (keep) chk("word_is_address", word_is_address, isa);
        if (keep) chk("word_data", word_data, w[7:0]);
    endtask

    // measure from one bit tick to the next, bounded
    task automatic bit_period(input int exp);
        int n;
        n = 0;
        while (bit_tick !== 1'b1 && n < 400) begin
            @(negedge clk);
            n++;
        end
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (bit_tick !== 1'b1 && n < 400);
        chk("bit_period", n[8:0], exp[8:0]);
    endtask

    task automatic frame;
        @(negedge clk);
        line.send(8'h55);
    endtask

    task automatic t_regs;
        for (int a = 0; a < 8; a++) rdchk("reset_value", a[2:0], 8'h00);
        chk("irq_reset", irq, 1'b0);
        wr(UCW_ADDR_CTRL, 8'hFF);
        rdchk("ctrl_mask", UCW_ADDR_CTRL, 8'h7C);
        chk("high_speed", baud_high_speed_select, 1'b1);
        chk("nine_bit", nine_bit_word_select, 1'b1);
        wr(UCW_ADDR_DIV, 8'hA5);
        chk("divider", baud_divider_value, 8'hA5);
        wr(UCW_ADDR_RXDATA, 8'h33);
        rdchk("rxdata_ro", UCW_ADDR_RXDATA, 8'h00);
        wr(UCW_ADDR_CTRL, 8'h00);
    endtask

    task automatic t_baud;
        wr(UCW_ADDR_CLKCTRL, 8'h01);
        chk("clock_on", serial_clock_on, 1'b1);
        wr(UCW_ADDR_DIV, 8'h01);
        for (int s = 1; s >= 0; s--) begin
            wr(UCW_ADDR_CTRL, s ? 8'h20 : 8'h00);
            bit_period(s ? 32 : 128);
        end
        wr(UCW_ADDR_DIV, 8'h00);
        bit_period(64);
    endtask

    task automatic t_addr;
        wr(UCW_ADDR_MASK, 8'h07);
        for (int nb = 0; nb < 2; nb++) begin
            wr(UCW_ADDR_CTRL, nb ? 8'h54 : 8'h14);
            send_word(nb ? 9'h1A5 : 9'h0A5, 1'b1, 1'b1);
            rdchk("addr_status", UCW_ADDR_STATUS, 8'h02);
            chk("addr_irq", irq, 1'b1);
            rdchk("rxinfo_addr", UCW_ADDR_RXINFO, nb ? 8'h03 : 8'h01);
            wr(UCW_ADDR_STATUS, 8'h02);
            send_word(nb ? 9'h0A5 : 9'h125, 1'b0, 1'b0);
            rdchk("drop_status", UCW_ADDR_STATUS, 8'h00);
        end
        wr(UCW_ADDR_CTRL, 8'h04);
        send_word(9'h1FF, 1'b1, 1'b0);
        rdchk("plain_status", UCW_ADDR_STATUS, 8'h00);
        rdchk("rxdata", UCW_ADDR_RXDATA, 8'hFF);
        rdchk("rxinfo_plain", UCW_ADDR_RXINFO, 8'h02);
        wr(UCW_ADDR_CLKCTRL, 8'h00);
        send_word(9'h133, 1'b0, 1'b0);
    endtask

    task automatic t_flags;
        wr(UCW_ADDR_MASK, 8'h01);
        for (int i = 0; i < 3; i++) begin
            wr(UCW_ADDR_CTRL, i < 2 ? 8'h04 : 8'h00);
            @(posedge clk);
            if (i == 0) overrun_flag <= 1'b1;
            else receive_available_flag <= 1'b1;
            @(posedge clk);
            overrun_flag <= 1'b0;
            receive_available_flag <= 1'b0;
            rdchk("rx_event", UCW_ADDR_STATUS, i < 2 ? 8'h01 : 8'h00);
            chk("rx_irq", irq, i < 2);
            wr(UCW_ADDR_STATUS, 8'h01);
        end
        chk("irq_cleared", irq, 1'b0);
    endtask

    task automatic t_wake;
        wr(UCW_ADDR_MASK, 8'h04);
        frame();
        chk("wake_disabled", wake_request, 1'b0);
        wr(UCW_ADDR_CTRL, 8'h08);
        frame();
        chk("wake_req", wake_request, 1'b1);
        chk("wake_irq", irq, 1'b1);
        rdchk("wake_status", UCW_ADDR_STATUS, 8'h04);
        wr(UCW_ADDR_CLKCTRL, 8'h01);
        repeat (3) @(negedge clk);
        chk("wake_cleared", wake_request, 1'b0);
        rdchk("wake_sticky", UCW_ADDR_STATUS, 8'h04);
        wr(UCW_ADDR_STATUS, 8'h04);
        frame();
        chk("wake_clock_on", wake_request, 1'b0);
        rdchk("wake_none", UCW_ADDR_STATUS, 8'h00);
    endtask

    // main sequence: reset for five cycles, then each scenario in turn
    initial begin
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        t_regs();
        t_baud();
        t_addr();
        t_flags();
        t_wake();
        final_report();
    end

    // watchdog, well beyond the thousand or so cycles the scenarios need
    initial begin
        #(1_000_000);
        n_fail++;
        final_report();
    end
endmodule
